// File: src/lcd_segment_pkg.sv
// Shared constants, level codes and default segment map of the LCD driver
package lcd_segment_pkg;

    // ------------------------------------------------------------------
    // Bus and memory layout
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W     = 16;
    localparam int unsigned DATA_W     = 4;
    localparam int unsigned MEM_WORDS  = 160;
    localparam int unsigned NUM_COM    = 8;
    localparam int unsigned NUM_SEG    = 64;
    localparam int unsigned NUM_PAIRS  = 32;
    localparam int unsigned MAP_W      = 10;
    localparam int unsigned MAP_SLOTS  = NUM_COM * NUM_SEG;

    localparam logic [15:0] ADDR_CTRL      = 16'hff60;
    localparam logic [15:0] ADDR_BLANK     = 16'hff61;
    localparam logic [15:0] ADDR_MEM_FIRST = 16'hf000;
    localparam logic [15:0] ADDR_MEM_LAST  = 16'hf09f;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_POWER_BIT     = 0;
    localparam int unsigned CTRL_STATIC_BIT    = 1;
    localparam int unsigned CTRL_DUTY_LOW_BIT  = 2;
    localparam int unsigned CTRL_DUTY_HIGH_BIT = 3;
    localparam int unsigned BLANK_RATE_BIT     = 0;
    localparam int unsigned BLANK_LIT_BIT      = 1;
    localparam int unsigned BLANK_DARK_BIT     = 2;
    localparam logic [3:0]  CTRL_RESET         = 4'h0;
    localparam logic [3:0]  BLANK_RESET        = 4'h4;

    // Drive level codes: ground, low, mid and high drive voltage
    typedef enum logic [1:0] {
        LVL_GND  = 2'h0,
        LVL_LOW  = 2'h1,
        LVL_MID  = 2'h2,
        LVL_HIGH = 2'h3
    } level_t;

    // ------------------------------------------------------------------
    // Timing: frame split into 40 subticks (common multiple of 4, 5, 8)
    // ------------------------------------------------------------------
    localparam longint CLK_HZ          = 200_000_000;
    localparam longint FRAME_FAST_MHZ  = 32000;
    localparam longint FRAME_SLOW_MHZ  = 25600;
    localparam longint SUBTICKS        = 40;
    localparam int unsigned PRESCALE_FAST_CYC =
        int'((CLK_HZ * 1000) / (FRAME_FAST_MHZ * SUBTICKS));
    localparam int unsigned PRESCALE_SLOW_CYC =
        int'((CLK_HZ * 1000) / (FRAME_SLOW_MHZ * SUBTICKS));
    localparam logic [2:0] LAST_SLOT_QUARTER = 3'h3;
    localparam logic [2:0] LAST_SLOT_FIFTH   = 3'h4;
    localparam logic [2:0] LAST_SLOT_EIGHTH  = 3'h7;
    localparam logic [3:0] TICKS_QUARTER     = 4'(SUBTICKS / 4);
    localparam logic [3:0] TICKS_FIFTH       = 4'(SUBTICKS / 5);
    localparam logic [3:0] TICKS_EIGHTH      = 4'(SUBTICKS / 8);

    // Default decoder: slot c of segment s reads bit (c*64+s) of memory
    function automatic logic [MAP_SLOTS*MAP_W-1:0] default_seg_map();
        logic [MAP_SLOTS*MAP_W-1:0] m;
        m = '0;
        for (int i = 0; i < MAP_SLOTS; i++) begin
            m[i*MAP_W +: MAP_W] = MAP_W'(i);
        end
        return m;
    endfunction

endpackage

// File: src/lcd_frame_timer.sv
// Frame timer: subtick prescaler, common slot counter and AC polarity
`timescale 1ns/100ps
`default_nettype none

module lcd_frame_timer #(
    parameter int unsigned PRESCALE_FAST = lcd_segment_pkg::PRESCALE_FAST_CYC,
    parameter int unsigned PRESCALE_SLOW = lcd_segment_pkg::PRESCALE_SLOW_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       slowRate,
    input  wire logic [3:0] ticksPerSlot,
    input  wire logic [2:0] lastSlot,
    output logic      [2:0] slot,
    output logic            polarity
);
    logic [31:0] preCnt_reg;
    logic [3:0]  tickCnt_reg;
    logic        subTick;
    logic [31:0] preLimit;

    // ------------------------------------------------------------------
    // Subtick enable pulse
    // ------------------------------------------------------------------
    assign preLimit = slowRate ? PRESCALE_SLOW - 32'h1 : PRESCALE_FAST - 32'h1;
    assign subTick  = run && (preCnt_reg >= preLimit);

    // Prescaler restarts while the display is unpowered
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run || subTick) begin
            preCnt_reg <= 32'h0;
        end else begin
            preCnt_reg <= preCnt_reg + 32'h1;
        end
    end

    // Equal slots: each common gets the same number of subticks
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            tickCnt_reg <= 4'h0;
            slot        <= 3'h0;
            polarity    <= 1'b0;
        end else if (subTick) begin
            if (tickCnt_reg >= ticksPerSlot - 4'h1) begin
                tickCnt_reg <= 4'h0;
                if (slot >= lastSlot) begin
                    slot     <= 3'h0;
                    polarity <= ~polarity; // AC inversion per frame
                end else begin
                    slot <= slot + 3'h1;
                end
            end else begin
                tickCnt_reg <= tickCnt_reg + 4'h1;
            end
        end
    end

endmodule

`default_nettype wire

// File: src/lcd_segment_driver.sv
// Segment LCD driver: control registers, display memory, waveform select
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Eight common and sixty-four segment outputs, up to 512 segments.
// - Multiplexed drive at 1/4, 1/5 or 1/8 duty with 1/3 bias levels.
// - Power bit one supplies the three drive levels to outputs.
// - DC-output segment pins ignore the power bit.
// - All-lit forces on-waveforms, all-dark off-waveforms, else memory.
// - All-lit wins when both blanking bits are set.
// - Duty field: 1x eighth, 01 fifth, 00 quarter duty.
// - Rate bit picks 25.6 or 32 Hz; fifth duty always 25.6 Hz.
// - Static drive only with the external half-bias supply option.
// - Static: on-waveform if any slot bit set, else off-waveform.
// - Display memory at F000H-F09FH, bits routed by a fixed decoder.
// - Memory bit one lights its segment, zero leaves it dark.
// - Display memory is not cleared by reset.
// - Memory is read/write; unmapped words serve as plain storage.
// - Decoder may map any memory bit to any segment and slot.
// - DC-output pin drives the memory bit of its common-zero slot.
// - DC or waveform output is chosen per even/odd pin pair.
// - Power bit zero collapses every drive level to ground.
// - After reset power is off and all-dark is set.
module lcd_segment_driver #(
    parameter int unsigned PRESCALE_FAST = lcd_segment_pkg::PRESCALE_FAST_CYC,
    parameter int unsigned PRESCALE_SLOW = lcd_segment_pkg::PRESCALE_SLOW_CYC,
    parameter bit          EXT_HALF_BIAS = 1'b0,
    parameter logic [31:0] DC_PAIRS      = 32'h0,
    parameter logic [lcd_segment_pkg::MAP_SLOTS*lcd_segment_pkg::MAP_W-1:0]
                           SEG_MAP       = lcd_segment_pkg::default_seg_map()
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [15:0]  regAddr,
    input  wire logic [3:0]   regWdata,
    input  wire logic         regWr,
    input  wire logic         regRd,
    output logic      [3:0]   regRdata,
    output logic      [15:0]  common_outputs,
    output logic      [127:0] segment_outputs,
    output logic      [63:0]  segDcData,
    output logic      [63:0]  segDcEnable,
    output logic              drivePowered
);
    localparam int unsigned NSEG = lcd_segment_pkg::NUM_SEG;
    localparam int unsigned NCOM = lcd_segment_pkg::NUM_COM;
    localparam int unsigned MW   = lcd_segment_pkg::MAP_W;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Never reset: contents start undefined
    logic [3:0] dispMem [0:lcd_segment_pkg::MEM_WORDS-1];
    logic       display_power_on;
    logic       static_drive_select;
    logic       duty_select_low;
    logic       duty_select_high;
    logic       frame_rate_select;
    logic       all_segments_lit;
    logic       all_segments_dark;

    logic       memHit;
    logic [7:0] memIndex;
    logic [2:0] slot;
    logic       polarity;
    logic [2:0] lastSlot;
    logic [3:0] ticksPerSlot;
    logic       slowRate;
    logic       staticMode;

    // Looks up the memory bit that the decoder routes to segment and slot
    // Entry is {word, bit} of the display memory
    function automatic logic mapped_bit(input int unsigned seg,
                                        input int unsigned com);
        logic [MW-1:0] e;
        e = SEG_MAP[(com*NSEG + seg)*MW +: MW];
        return dispMem[e[MW-1:2]][e[1:0]];
    endfunction

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    // Memory window F000H-F09FH, offset into the word array
    // Control addresses are full 16-bit matches
    assign memIndex = regAddr[7:0];
    assign memHit   = (regAddr >= lcd_segment_pkg::ADDR_MEM_FIRST) &&
                      (regAddr <= lcd_segment_pkg::ADDR_MEM_LAST);

    // Out-of-range words are never written
    // Display memory writes; no reset so contents start unknown
    always_ff @(posedge sys_clk) begin
        if (regWr && memHit) begin
            dispMem[memIndex] <= regWdata;
        end
    end

    // Drive control word: power, static, duty
    // Static bit is kept even if the supply ignores it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            display_power_on <=
                lcd_segment_pkg::CTRL_RESET[lcd_segment_pkg::CTRL_POWER_BIT];
            static_drive_select <=
                lcd_segment_pkg::CTRL_RESET[lcd_segment_pkg::CTRL_STATIC_BIT];
            duty_select_low <= lcd_segment_pkg::CTRL_RESET[
                lcd_segment_pkg::CTRL_DUTY_LOW_BIT];
            duty_select_high <= lcd_segment_pkg::CTRL_RESET[
                lcd_segment_pkg::CTRL_DUTY_HIGH_BIT];
        end else if (regWr && regAddr == lcd_segment_pkg::ADDR_CTRL) begin
            display_power_on <=
                regWdata[lcd_segment_pkg::CTRL_POWER_BIT];
            static_drive_select <=
                regWdata[lcd_segment_pkg::CTRL_STATIC_BIT];
            duty_select_low <=
                regWdata[lcd_segment_pkg::CTRL_DUTY_LOW_BIT];
            duty_select_high <=
                regWdata[lcd_segment_pkg::CTRL_DUTY_HIGH_BIT];
        end
    end

    // Blanking and frame rate word; all-dark set after reset
    // All-lit outranks all-dark further down
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            frame_rate_select <=
                lcd_segment_pkg::BLANK_RESET[lcd_segment_pkg::BLANK_RATE_BIT];
            all_segments_lit <=
                lcd_segment_pkg::BLANK_RESET[lcd_segment_pkg::BLANK_LIT_BIT];
            all_segments_dark <=
                lcd_segment_pkg::BLANK_RESET[lcd_segment_pkg::BLANK_DARK_BIT];
        end else if (regWr && regAddr == lcd_segment_pkg::ADDR_BLANK) begin
            frame_rate_select <=
                regWdata[lcd_segment_pkg::BLANK_RATE_BIT];
            all_segments_lit <=
                regWdata[lcd_segment_pkg::BLANK_LIT_BIT];
            all_segments_dark <=
                regWdata[lcd_segment_pkg::BLANK_DARK_BIT];
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    // Idle cycles read zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            regRdata <= 4'h0;
        end else if (regRd) begin
            if (memHit) begin
                regRdata <= dispMem[memIndex];
            end else if (regAddr == lcd_segment_pkg::ADDR_CTRL) begin
                regRdata <= {duty_select_high, duty_select_low,
                             static_drive_select, display_power_on};
            end else if (regAddr == lcd_segment_pkg::ADDR_BLANK) begin
                regRdata <= {1'b0, all_segments_dark, all_segments_lit,
                             frame_rate_select};
            end else begin
                regRdata <= 4'h0;
            end
        end else begin
            regRdata <= 4'h0;
        end
    end

    // ------------------------------------------------------------------
    // Duty, rate and frame timing
    // ------------------------------------------------------------------
    // Duty field decode: high bit wins, then low bit
    // Lower duty bit is ignored under eighth duty
    always_comb begin
        if (duty_select_high) begin
            lastSlot     = lcd_segment_pkg::LAST_SLOT_EIGHTH;
            ticksPerSlot = lcd_segment_pkg::TICKS_EIGHTH;
        end else if (duty_select_low) begin
            lastSlot     = lcd_segment_pkg::LAST_SLOT_FIFTH;
            ticksPerSlot = lcd_segment_pkg::TICKS_FIFTH;
        end else begin
            lastSlot     = lcd_segment_pkg::LAST_SLOT_QUARTER;
            ticksPerSlot = lcd_segment_pkg::TICKS_QUARTER;
        end
    end

    // Fifth duty is pinned to the slow rate
    assign slowRate = frame_rate_select ||
                      (!duty_select_high && duty_select_low);

    // Static drive exists only with the half-bias external supply
    assign staticMode = EXT_HALF_BIAS && static_drive_select;

    // Timer sits at reset while unpowered; a rate change takes effect at once, without a power cycle
    // A rate change mid-frame would bend one subtick
    // Slot and polarity; outputs lag them a cycle
    lcd_frame_timer #(
        .PRESCALE_FAST (PRESCALE_FAST),
        .PRESCALE_SLOW (PRESCALE_SLOW)
    ) u_timer (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .run          (display_power_on),
        .slowRate     (slowRate),
        .ticksPerSlot (ticksPerSlot),
        .lastSlot     (lastSlot),
        .slot         (slot),
        .polarity     (polarity)
    );

    // ------------------------------------------------------------------
    // Waveform levels
    // ------------------------------------------------------------------
    // Each pin carries a two-bit level code
    logic [15:0]  comNext;
    logic [127:0] segNext;
    logic [63:0]  dcNext;
    logic [63:0]  dcEnNext;

    // Common levels: active slot selected, the rest non-selected
    // Polarity 0: selected common high, rest low
    // Polarity 1: selected common ground, rest mid
    // Static mode selects every common at once
    always_comb begin
        comNext = '0;
        for (int c = 0; c < NCOM; c++) begin
            if (!display_power_on) begin
                comNext[c*2 +: 2] = lcd_segment_pkg::LVL_GND;
            end else if (staticMode ||
                         (3'(c) == slot && 3'(c) <= lastSlot)) begin
                comNext[c*2 +: 2] = polarity ? lcd_segment_pkg::LVL_GND
                                             : lcd_segment_pkg::LVL_HIGH;
            end else begin
                comNext[c*2 +: 2] = polarity ? lcd_segment_pkg::LVL_MID
                                             : lcd_segment_pkg::LVL_LOW;
            end
        end
    end

    // Segment levels and DC pin data
    // Lit segment: three steps from the selected common
    // Dark segment: one step, under the on threshold
    // Normal drive shows the active slot's bit
    always_comb begin
        logic lit;
        logic anySet;
        lit      = 1'b0;
        anySet   = 1'b0;
        segNext  = '0;
        dcNext   = '0;
        dcEnNext = '0;
        for (int s = 0; s < NSEG; s++) begin
            anySet = 1'b0;
            // Static drive lights a segment if any slot bit is set
            for (int c = 0; c < NCOM; c++) begin
                anySet = anySet | mapped_bit(s, c);
            end
            if (all_segments_lit) begin
                lit = 1'b1;
            end else if (all_segments_dark) begin
                lit = 1'b0;
            end else if (staticMode) begin
                lit = anySet;
            end else begin
                lit = mapped_bit(s, int'(slot));
            end
            // DC pins skip blanking, power and inversion
            if (DC_PAIRS[s/2]) begin
                dcEnNext[s] = 1'b1;
                dcNext[s]   = mapped_bit(s, 0);
            end else if (!display_power_on) begin
                segNext[s*2 +: 2] = lcd_segment_pkg::LVL_GND;
            end else if (lit) begin
                segNext[s*2 +: 2] = polarity ? lcd_segment_pkg::LVL_HIGH
                                             : lcd_segment_pkg::LVL_GND;
            end else begin
                segNext[s*2 +: 2] = polarity ? lcd_segment_pkg::LVL_LOW
                                             : lcd_segment_pkg::LVL_MID;
            end
        end
    end

    // Output stage registers; drive levels exist only when powered
    // Pins change only on the clock edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            common_outputs  <= '0;
            segment_outputs <= '0;
            segDcData       <= '0;
            segDcEnable     <= '0;
            drivePowered    <= 1'b0;
        end else begin
            common_outputs  <= comNext;
            segment_outputs <= segNext;
            segDcData       <= dcNext;
            segDcEnable     <= dcEnNext;
            drivePowered    <= display_power_on;
        end
    end

endmodule

`default_nettype wire

// File: tb/lcd_segment_driver_monitor.sv
// Port checker of the segment LCD driver, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module lcd_segment_driver_monitor #(
    parameter logic [31:0] DC_PAIRS = 32'h0
) (
    input wire logic         sys_clk,
    input wire logic         rst_n,
    input wire logic [15:0]  regAddr,
    input wire logic [3:0]   regWdata,
    input wire logic         regWr,
    input wire logic         regRd,
    input wire logic [3:0]   regRdata,
    input wire logic [15:0]  common_outputs,
    input wire logic [127:0] segment_outputs,
    input wire logic [63:0]  segDcEnable,
    input wire logic         drivePowered
);
    logic [3:0]  ctrlShadow;
    logic [63:0] dcExp;
    logic        otherAddr;
    default clocking mcb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Control word as software last wrote it
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            ctrlShadow <= 4'h0;
        else if (regWr && regAddr == lcd_segment_pkg::ADDR_CTRL)
            ctrlShadow <= regWdata;
    end
    // Pair option widened to one bit per pin
    always_comb begin
        for (int i = 0; i < 64; i++)
            dcExp[i] = DC_PAIRS[i/2];
    end
    // Address outside memory and both control words
    assign otherAddr = (regAddr < lcd_segment_pkg::ADDR_MEM_FIRST
        || regAddr > lcd_segment_pkg::ADDR_MEM_LAST)
        && regAddr != lcd_segment_pkg::ADDR_CTRL
        && regAddr != lcd_segment_pkg::ADDR_BLANK;
    reset_quiet_a: assert property (rst_n && !$past(rst_n) |->
        !drivePowered && common_outputs == 16'h0) else $error("not quiet");
    power_write_a: assert property (regWr && regAddr ==
        lcd_segment_pkg::ADDR_CTRL |=> ##1 drivePowered ==
        $past(regWdata[0], 2)) else $error("power bit not applied");
    ctrl_readback_a: assert property (regRd && regAddr ==
        lcd_segment_pkg::ADDR_CTRL |=> regRdata == ctrlShadow)
        else $error("control readback wrong");
    unmapped_read_a: assert property (regRd && otherAddr
        |=> regRdata == 4'h0) else $error("unmapped read not zero");
    idle_read_a: assert property (!regRd |=> regRdata == 4'h0)
        else $error("read data outside its cycle");
    power_off_a: assert property (!drivePowered [*3] |->
        common_outputs == 16'h0 && segment_outputs == 128'h0)
        else $error("drive while powered off");
    dc_pairs_a: assert property (rst_n && $past(rst_n) |->
        segDcEnable == dcExp) else $error("DC pair enables wrong");
    dc_ground_a: assert property (segDcEnable[0] |->
        segment_outputs[1:0] == 2'h0) else $error("DC pin has waveform");
    idle_commons_a: assert property ((ctrlShadow == 4'h1 &&
        $stable(ctrlShadow)) [*4] |-> common_outputs[15:8] inside
        {8'h55, 8'haa}) else $error("unused common selected");
endmodule
bind lcd_segment_driver lcd_segment_driver_monitor #(
    .DC_PAIRS(DC_PAIRS)
) mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .common_outputs(common_outputs),
    .segment_outputs(segment_outputs), .segDcEnable(segDcEnable),
    .drivePowered(drivePowered)
);
`default_nettype wire

// File: tb/lcd_glass_panel.sv
// Glass panel model: records cells that see full drive across them
`timescale 1ns/100ps
`default_nettype none
module lcd_glass_panel (
    input  wire logic         sys_clk,
    input  wire logic         clearSeen,
    input  wire logic [15:0]  common_outputs,
    input  wire logic [127:0] segment_outputs,
    output logic      [511:0] seen,
    output logic      [7:0]   comUsed
);
    // A cell lights only across the full three-step level gap
    always_ff @(posedge sys_clk) begin
        if (clearSeen) begin
            seen    <= '0;
            comUsed <= '0;
        end else begin
            for (int c = 0; c < 8; c++) begin
                if (common_outputs[2*c +: 2] == 2'h3)
                    comUsed[c] <= 1'b1;
                for (int s = 0; s < 64; s++) begin
                    if ((common_outputs[2*c +: 2] ^ segment_outputs[2*s +: 2])
                        == 2'h3 &&
                        common_outputs[2*c] == common_outputs[2*c+1])
                        seen[c*64+s] <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/lcd_segment_driver_bench.sv
// Self-checking bench of the segment LCD driver
`timescale 1ns/100ps
`default_nettype none
module lcd_segment_driver_bench;
    localparam logic [511:0] QMASK = {256'h0, {4{64'hffff_ffff_ffff_fffc}}};
    logic         sys_clk;
    logic         rst_n;
    logic [15:0]  regAddr;
    logic [3:0]   regWdata;
    logic         regWr;
    logic         regRd;
    logic [3:0]   regRdata;
    logic [15:0]  common_outputs;
    logic [127:0] segment_outputs;
    logic [63:0]  segDcData;
    logic [63:0]  segDcEnable;
    logic         drivePowered;
    logic         clearSeen;
    logic [511:0] seen;
    logic [7:0]   comUsed;
    int           bad_count;
    int           num_checks;
    int           cycles;
    int           hi;
    int           per;
    logic [3:0]   rowCtrl[5]  = '{4'h1, 4'h1, 4'h5, 4'h9, 4'hd};
    logic [3:0]   rowBlank[5] = '{4'h0, 4'h1, 4'h0, 4'h0, 4'h1};
    int           rowHi[5]    = '{40, 50, 40, 20, 25};
    int           rowPer[5]   = '{320, 400, 400, 320, 400};
    logic [7:0]   rowUsed[5]  = '{8'h0f, 8'h0f, 8'h1f, 8'hff, 8'hff};
    lcd_segment_driver #(
        .PRESCALE_FAST(4), .PRESCALE_SLOW(5), .EXT_HALF_BIAS(1'b1),
        .DC_PAIRS(32'h1)
    ) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .common_outputs(common_outputs),
        .segment_outputs(segment_outputs), .segDcData(segDcData),
        .segDcEnable(segDcEnable), .drivePowered(drivePowered)
    );
    lcd_glass_panel panel (
        .sys_clk(sys_clk), .clearSeen(clearSeen),
        .common_outputs(common_outputs), .segment_outputs(segment_outputs),
        .seen(seen), .comUsed(comUsed)
    );
    // Clock generator
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [511:0] got, input logic [511:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge sys_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [3:0] exp);
        @(posedge sys_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        chk(regRdata, exp);
    endtask
    // Clear the panel record, then let the display run n cycles
    task automatic watch(input int n);
        @(posedge sys_clk) clearSeen <= 1'b1;
        @(posedge sys_clk) clearSeen <= 1'b0;
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // Time common 0 at its selected level, and its repeat period
    task automatic frame_meas();
        realtime t0;
        while (common_outputs[1:0] === 2'h3) @(negedge sys_clk);
        while (common_outputs[1:0] !== 2'h3) @(negedge sys_clk);
        t0 = $realtime;
        while (common_outputs[1:0] === 2'h3) @(negedge sys_clk);
        hi = int'(($realtime - t0) / 5.0);
        while (common_outputs[1:0] !== 2'h3) @(negedge sys_clk);
        per = int'(($realtime - t0) / 5.0);
    endtask
    task automatic t_reset();
        rd(lcd_segment_pkg::ADDR_CTRL, 4'h0);
        rd(lcd_segment_pkg::ADDR_BLANK, 4'h4);
        rd(16'hff62, 4'h0);
        $display("reset test done");
    endtask
    task automatic t_mem();
        for (int i = 0; i < 160; i++)
            wr(lcd_segment_pkg::ADDR_MEM_FIRST + 16'(i), 4'(i) ^ 4'h5);
        for (int i = 0; i < 160; i++)
            rd(lcd_segment_pkg::ADDR_MEM_FIRST + 16'(i),
               4'(i) ^ 4'h5);
        wr(16'hf0a0, 4'hf);
        rd(16'hf0a0, 4'h0);
        for (int i = 0; i < 160; i++)
            wr(lcd_segment_pkg::ADDR_MEM_FIRST + 16'(i), 4'h0);
        $display("memory test done");
    endtask
    task automatic t_map();
        wr(16'hf000, 4'h1);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(segDcEnable, 64'h3);
        chk(segDcData[1:0], 2'h1);
        chk({common_outputs, segment_outputs}, 144'h0);
        wr(lcd_segment_pkg::ADDR_BLANK, 4'h0);
        wr(lcd_segment_pkg::ADDR_CTRL, 4'h1);
        wr(16'hf001, 4'h1);
        wr(16'hf011, 4'h2);
        watch(400);
        chk(seen & QMASK, (512'h1 << 4) | (512'h1 << 69));
        chk(comUsed, 8'h0f);
        chk(segDcData[0], 1'b1);
        for (int v = 1; v < 4; v++) begin
            wr(lcd_segment_pkg::ADDR_BLANK, 4'(v << 1));
            watch(400);
            chk(seen & QMASK, (v == 2) ? 512'h0 : QMASK);
        end
        $display("mapping and blanking test done");
    endtask
    task automatic t_rate();
        for (int r = 0; r < 5; r++) begin
            wr(lcd_segment_pkg::ADDR_CTRL, 4'h0);
            wr(lcd_segment_pkg::ADDR_BLANK, rowBlank[r]);
            wr(lcd_segment_pkg::ADDR_CTRL, rowCtrl[r]);
            watch(900);
            chk(comUsed, rowUsed[r]);
            frame_meas();
            chk(hi, rowHi[r]);
            chk(per, rowPer[r]);
        end
        $display("duty and rate test done");
    endtask
    task automatic t_static();
        wr(lcd_segment_pkg::ADDR_CTRL, 4'h0);
        wr(16'hf001, 4'h0);
        wr(16'hf011, 4'h0);
        wr(16'hf051, 4'h1);
        wr(lcd_segment_pkg::ADDR_BLANK, 4'h0);
        wr(lcd_segment_pkg::ADDR_CTRL, 4'h3);
        watch(400);
        chk(seen[63:0] & 64'hffff_ffff_ffff_fffc, 64'h10);
        wr(lcd_segment_pkg::ADDR_CTRL, 4'h0);
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(common_outputs, 16'h0);
        $display("static test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_n     = 1'b0;
        regAddr   = 16'h0;
        regWdata  = 4'h0;
        regWr     = 1'b0;
        regRd     = 1'b0;
        clearSeen = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_mem();
        t_map();
        t_rate();
        t_static();
        tally_and_finish();
    end
endmodule
`default_nettype wire
